// File: common/flash_host_pkg.sv
// package for the flash identification/query host controller
// assumes one 250 MHz pclk domain and an apb slave port
package flash_host_pkg;

    // ***************************************************
    // register offsets (byte addresses on apb)
    // ***************************************************
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_ADDR = 8'h04;
    localparam logic [7:0] OFF_WDATA = 8'h08;
    localparam logic [7:0] OFF_RDATA = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_TIMING = 8'h14;

    // ***************************************************
    // control fields
    // ***************************************************
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_WRITE_BIT = 1;
    localparam int CTRL_BYTE_BIT = 2;
    localparam int CTRL_A9_HV_BIT = 3;
    localparam int CTRL_RST_HV_BIT = 4;
    localparam int CTRL_RST_N_BIT = 5;
    localparam logic [5:0] CTRL_RESET = 6'h20;
    localparam logic [7:0] TIMING_RESET = 8'h13;

    // ***************************************************
    // device command codes and addresses
    // ***************************************************
    localparam logic [15:0] CMD_QUERY = 16'h0098;
    localparam logic [15:0] CMD_RESET = 16'h00f0;
    localparam logic [19:0] QUERY_WORD_ADDR = 20'h0_0055;
    localparam logic [20:0] QUERY_BYTE_ADDR = 21'h00_00aa;

    // query table offsets (word mode)
    localparam logic [7:0] QRY_LETTER_Q = 8'h10;
    localparam logic [7:0] QRY_LETTER_R = 8'h11;
    localparam logic [7:0] QRY_LETTER_Y = 8'h12;
    localparam logic [7:0] QRY_PRI_LO = 8'h13;
    localparam logic [7:0] QRY_PRI_HI = 8'h14;
    localparam logic [7:0] QRY_PEXT_LO = 8'h15;
    localparam logic [7:0] QRY_PEXT_HI = 8'h16;
    localparam logic [7:0] QRY_ALT_LO = 8'h17;
    localparam logic [7:0] QRY_ALT_HI = 8'h18;
    localparam logic [7:0] QRY_AEXT_LO = 8'h19;
    localparam logic [7:0] QRY_AEXT_HI = 8'h1a;
    localparam logic [15:0] QRY_Q_VAL = 16'h0051;
    localparam logic [15:0] QRY_R_VAL = 16'h0052;
    localparam logic [15:0] QRY_Y_VAL = 16'h0059;

    // identifier address lines
    localparam int ID_LOW_BIT = 0;
    localparam int ID_MID_BIT = 1;
    localparam int ID_HIGH_BIT = 6;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_STROBE = 3'b010,
        ST_HOLD = 3'b011,
        ST_DONE = 3'b100
    } cyc_state_t;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic byte_n;
        logic reset_n;
        logic a9_hv;
        logic reset_hv;
    } flash_ctl_t;

endpackage

// File: verilog/flash_host.sv
// host controller that drives a parallel nor flash for id and query access
// assumes apb master software, flash pins on the far side, one clock
//
// Operation
// - programmer method holds high voltage on the id address line
// - protect method: high voltage on reset pin, normal bus cycles
// - host leaves sector protect sequencing to firmware; it only runs single cycles
// - host drives the addr register onto the address pins unchanged in word mode; byte mode shifts it right, bit 0 to the lsb pin
// - firmware writes reset command to leave query mode
`timescale 1ns/100ps
module flash_host
    import flash_host_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [19:0] flash_addr,
    output logic flash_addr_lsb,
    output logic [15:0] flash_dq_out,
    output logic flash_dq_oe,
    input wire logic [15:0] flash_dq_in,
    output flash_ctl_t flash_ctl,
    output logic query_ok
);

    // ***************************************************
    // registers
    // ***************************************************
    logic [5:0] ctrl_r;
    logic [20:0] addr_r;
    logic [15:0] wdata_r;
    logic [15:0] rdata_r;
    logic busy_r;
    logic [7:0] timing_r;
    logic [7:0] cnt_r;
    cyc_state_t state_r;
    cyc_state_t state_nxt;
    logic [15:0] dq_s1_r;
    logic [15:0] dq_s2_r;
    logic [31:0] prdata_r;
    logic qok_r;

    wire bus_wr = psel && penable && pwrite;
    wire bus_rd = psel && !penable && !pwrite;
    wire go = bus_wr && paddr == OFF_CTRL && pwdata[CTRL_GO_BIT] && !busy_r;
    wire byte_mode = ctrl_r[CTRL_BYTE_BIT];
    wire is_write = ctrl_r[CTRL_WRITE_BIT];
    wire cnt_done = cnt_r == 8'h00;

    // word mode: address bits 19:0; byte mode adds the byte-select lsb
    wire [19:0] word_addr = byte_mode ? addr_r[20:1] : addr_r[19:0];
    wire word_lsb = byte_mode ? addr_r[0] : 1'b0;

    // known query letter check on last read, for quick software probing
    wire [7:0] rd_off = byte_mode ? addr_r[8:1] : addr_r[7:0];
    wire qry_hit = (rd_off == QRY_LETTER_Q && rdata_r == QRY_Q_VAL) ||
        (rd_off == QRY_LETTER_R && rdata_r == QRY_R_VAL) ||
        (rd_off == QRY_LETTER_Y && rdata_r == QRY_Y_VAL);

    // ***************************************************
    // apb register file
    // ***************************************************
    logic [31:0] rd_mux;
    always_comb begin
        if (paddr == OFF_CTRL) begin
            rd_mux = {26'h000_0000, ctrl_r};
        end else if (paddr == OFF_ADDR) begin
            rd_mux = {11'h000, addr_r};
        end else if (paddr == OFF_WDATA) begin
            rd_mux = {16'h0000, wdata_r};
        end else if (paddr == OFF_RDATA) begin
            rd_mux = {16'h0000, rdata_r};
        end else if (paddr == OFF_STATUS) begin
            rd_mux = {30'h0000_0000, qok_r, busy_r};
        end else if (paddr == OFF_TIMING) begin
            rd_mux = {24'h00_0000, timing_r};
        end else begin
            rd_mux = 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= CTRL_RESET;
            addr_r <= 21'h00_0000;
            wdata_r <= 16'h0000;
            timing_r <= TIMING_RESET;
            prdata_r <= 32'h0000_0000;
        end else begin
            if (bus_rd) begin
                prdata_r <= rd_mux;
            end
            if (bus_wr && paddr == OFF_CTRL) begin
                // high voltage bits stay software-owned: sequencing of
                // protect algorithms is left to firmware
                ctrl_r <= {pwdata[5:1], 1'b0};
            end else if (bus_wr && paddr == OFF_ADDR && !busy_r) begin
                addr_r <= pwdata[20:0];
            end else if (bus_wr && paddr == OFF_WDATA && !busy_r) begin
                wdata_r <= pwdata[15:0];
            end else if (bus_wr && paddr == OFF_TIMING) begin
                timing_r <= pwdata[7:0];
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // ***************************************************
    // flash cycle sequencer
    // ***************************************************
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (go) begin
                    state_nxt = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (cnt_done) begin
                    state_nxt = ST_STROBE;
                end
            end
            ST_STROBE: begin
                if (cnt_done) begin
                    state_nxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (cnt_done) begin
                    state_nxt = ST_DONE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            cnt_r <= 8'h00;
            busy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            busy_r <= state_nxt != ST_IDLE;
            if (state_nxt != state_r) begin
                cnt_r <= state_nxt == ST_STROBE ? timing_r : 8'h01;
            end else if (!cnt_done) begin
                cnt_r <= cnt_r - 8'h01;
            end
        end
    end

    // pin input crosses from the flash: two flops before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dq_s1_r <= 16'h0000;
            dq_s2_r <= 16'h0000;
            rdata_r <= 16'h0000;
            qok_r <= 1'b0;
        end else begin
            dq_s1_r <= flash_dq_in;
            dq_s2_r <= dq_s1_r;
            // sample at end of strobe; timing_r must cover access time
            if (state_r == ST_STROBE && cnt_done && !is_write) begin
                rdata_r <= byte_mode ? {8'h00, dq_s2_r[7:0]} : dq_s2_r;
            end
            if (state_r == ST_DONE) begin
                qok_r <= qry_hit;
            end
        end
    end
    assign query_ok = qok_r;

    // ***************************************************
    // pins
    // ***************************************************
    logic [19:0] fa_r;
    logic fl_r;
    logic [15:0] dqo_r;
    logic dqoe_r;
    flash_ctl_t ctl_r;
    wire strobe = state_r == ST_STROBE;
    wire active = state_r != ST_IDLE && state_r != ST_DONE;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fa_r <= 20'h0_0000;
            fl_r <= 1'b0;
            dqo_r <= 16'h0000;
            dqoe_r <= 1'b0;
            ctl_r <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
        end else begin
            fa_r <= word_addr;
            fl_r <= word_lsb;
            dqo_r <= wdata_r;
            dqoe_r <= active && is_write;
            ctl_r.ce_n <= !active;
            ctl_r.oe_n <= !(strobe && !is_write);
            ctl_r.we_n <= !(strobe && is_write);
            ctl_r.byte_n <= !byte_mode;
            ctl_r.reset_n <= ctrl_r[CTRL_RST_N_BIT];
            ctl_r.a9_hv <= ctrl_r[CTRL_A9_HV_BIT];
            ctl_r.reset_hv <= ctrl_r[CTRL_RST_HV_BIT];
        end
    end
    assign flash_addr = fa_r;
    assign flash_addr_lsb = fl_r;
    assign flash_dq_out = dqo_r;
    assign flash_dq_oe = dqoe_r;
    assign flash_ctl = ctl_r;

    // ***************************************************
    // checks
    // ***************************************************
    a_no_oe_we_both: assert property (@(posedge pclk) disable iff (!presetn)
        !(!flash_ctl.oe_n && !flash_ctl.we_n)) else $error("oe and we low");
    a_dq_drive_write: assert property (@(posedge pclk) disable iff (!presetn)
        !flash_ctl.we_n |-> flash_dq_oe) else $error("write without drive");
    a_hv_follows_ctrl: assert property (@(posedge pclk) disable iff (!presetn)
        1 |=> flash_ctl.reset_hv == $past(ctrl_r[CTRL_RST_HV_BIT]))
        else $error("reset hv lag");
    a_a9hv_follows: assert property (@(posedge pclk) disable iff (!presetn)
        1 |=> flash_ctl.a9_hv == $past(ctrl_r[CTRL_A9_HV_BIT]))
        else $error("a9 hv lag");
    a_busy_on_go: assert property (@(posedge pclk) disable iff (!presetn)
        go |=> busy_r) else $error("go not taken");
    a_done_idle: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == ST_DONE |=> state_r == ST_IDLE) else $error("stuck done");
    a_ce_in_strobe: assert property (@(posedge pclk) disable iff (!presetn)
        !flash_ctl.oe_n |-> !flash_ctl.ce_n) else $error("oe without ce");
    a_byte_addr: assert property (@(posedge pclk) disable iff (!presetn)
        byte_mode |-> word_addr == addr_r[20:1]) else $error("byte map");

endmodule // flash_host

// File: dv/flash_dev_model.sv
// behavioural nor flash: identifier, protect and query reads
// assumes host pins from flash_host; no clock of its own
`timescale 1ns/100ps
module flash_dev_model
    import flash_host_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE = 8'h3c, // arbitrary value
    parameter logic [15:0] PART_CODE = 16'h5aa5 // arbitrary value
)(
    input wire logic [19:0] flash_addr,
    input wire logic flash_addr_lsb,
    input wire logic [15:0] flash_dq_out,
    input wire flash_ctl_t flash_ctl,
    output logic [15:0] flash_dq_in
);
    // ***************************************************
    // command capture on the rising write strobe
    // ***************************************************
    logic id_r = 1'b0;
    logic qry_r = 1'b0;
    logic from_id_r = 1'b0;
    logic [255:0] prot_r = '0;
    logic [15:0] rd_val;
    logic [15:0] last_q = '0;
    logic [19:0] a;
    logic rd_en;
    logic qry_hit;
    assign a = flash_addr;
    assign qry_hit = flash_ctl.byte_n ? (a == QUERY_WORD_ADDR)
                                      : ({a, flash_addr_lsb} == QUERY_BYTE_ADDR);
    always @(posedge flash_ctl.we_n) begin
        if (!flash_ctl.ce_n && flash_ctl.reset_n) begin
            if (flash_ctl.reset_hv && flash_dq_out[7:0] == 8'h60) begin
                prot_r[a[19:12]] = 1'b1;
            end else if (flash_dq_out[7:0] == 8'h98 && qry_hit) begin
                from_id_r = id_r;
                qry_r = 1'b1;
                id_r = 1'b0;
            end else if (flash_dq_out[7:0] == 8'hf0) begin
                id_r = qry_r & from_id_r;
                qry_r = 1'b0;
            end else if (flash_dq_out[7:0] == 8'h90) begin
                id_r = 1'b1;
            end
        end
    end
    // ***************************************************
    // read data
    // ***************************************************
    always_comb begin
        rd_val = 16'hffff;
        if (qry_r) begin
            rd_val = 16'h0000;
            if (a[19:7] == '0) begin
                case (a[6:0])
                    7'h10: rd_val = 16'h0051;
                    7'h11: rd_val = 16'h0052;
                    7'h12: rd_val = 16'h0059;
                    7'h13: rd_val = 16'h0002;
                    7'h15: rd_val = 16'h0040;
                    default: rd_val = 16'h0000;
                endcase
            end
        end else if ((flash_ctl.a9_hv || id_r) && !a[6]) begin
            if (!a[1]) begin
                rd_val = a[0] ? PART_CODE : {8'h00, MAKER_CODE};
            end else if (!a[0]) begin
                rd_val = {15'h0000, prot_r[a[19:12]]};
            end
        end
    end
    // released bus shows the inverse so a stale sample cannot pass
    assign rd_en = !flash_ctl.ce_n && !flash_ctl.oe_n;
    always @* if (rd_en) last_q = rd_val;
    assign flash_dq_in = rd_en ? rd_val : ~last_q;
endmodule // flash_dev_model

// File: dv/flash_host_tb_top.sv
// testbench: apb tasks drive id, protect and query flash cycles
// assumes flash_dev_model on the flash pins
`timescale 1ns/100ps
module flash_host_tb_top;
    import flash_host_pkg::*;
    localparam logic [7:0] MAKER = 8'h3c;
    localparam logic [15:0] PART = 16'h5aa5;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, flash_addr_lsb, flash_dq_oe, query_ok;
    logic [19:0] flash_addr;
    logic [15:0] flash_dq_out, flash_dq_in, q;
    flash_ctl_t flash_ctl;
    int n_fail = 0, checked = 0;
    logic [15:0] qtab [11] = '{16'h0051, 16'h0052, 16'h0059, 16'h0002,
        16'h0000, 16'h0040, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    flash_host DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flash_addr(flash_addr), .flash_addr_lsb(flash_addr_lsb),
        .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
        .flash_dq_in(flash_dq_in), .flash_ctl(flash_ctl), .query_ok(query_ok));
    flash_dev_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) far_end (
        .flash_addr(flash_addr), .flash_addr_lsb(flash_addr_lsb),
        .flash_dq_out(flash_dq_out), .flash_ctl(flash_ctl),
        .flash_dq_in(flash_dq_in));
    initial forever #2 pclk = ~pclk;
    // ***************************************************
    // tasks
    // ***************************************************
    task automatic summarize;
        $display("checked %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 100);
        if (i >= 100) begin n_fail++; summarize(); end
        d = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // one flash cycle; ctl bits 1 write, 2 byte, 3 a9 hv, 4 reset hv
    task automatic fcyc(input logic [5:0] ctl, input logic [20:0] ad,
                        input logic [15:0] wd, output logic [15:0] r);
        logic [31:0] s;
        int i;
        apb(1'b1, OFF_ADDR, {11'h000, ad}, s);
        apb(1'b1, OFF_WDATA, {16'h0000, wd}, s);
        apb(1'b1, OFF_CTRL, {26'h000_0000, ctl | 6'h21}, s);
        i = 0;
        do begin
            apb(1'b0, OFF_STATUS, 32'h0000_0000, s);
            i++;
        end while (s[0] !== 1'b0 && i < 50);
        if (i >= 50) begin n_fail++; summarize(); end
        apb(1'b0, OFF_RDATA, 32'h0000_0000, s);
        r = s[15:0];
    endtask
    // ***************************************************
    // sequence
    // ***************************************************
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFF_TIMING, 32'h0000_0000, rd);
        chk("timing", {24'h00_0000, TIMING_RESET}, rd);
        apb(1'b1, 8'h40, 32'hffff_ffff, rd);
        apb(1'b0, 8'h40, 32'h0000_0000, rd);
        chk("unmapped", 32'h0000_0000, rd);
        fcyc(6'h02, 21'h00_0055, 16'h0098, q);
        for (int k = 0; k < 11; k++) begin
            fcyc(6'h00, 21'h00_0010 + 21'(k), 16'h0000, q);
            chk("query word", 32'(qtab[k]), 32'(q));
            if (k == 2) chk("query ok", 32'h1, 32'(query_ok));
        end
        fcyc(6'h02, 21'h00_0000, 16'h00f0, q);
        fcyc(6'h00, 21'h00_0010, 16'h0000, q);
        chk("array after exit", 32'h0000_ffff, 32'(q));
        fcyc(6'h08, 21'h00_0000, 16'h0000, q);
        chk("maker", {24'h00_0000, MAKER}, 32'(q));
        fcyc(6'h08, 21'h00_0001, 16'h0000, q);
        chk("part", 32'(PART), 32'(q));
        fcyc(6'h08, 21'h01_0002, 16'h0000, q);
        chk("unprotected", 32'h0, 32'(q));
        fcyc(6'h12, 21'h01_0000, 16'h0060, q);
        fcyc(6'h08, 21'h01_0002, 16'h0000, q);
        chk("protected", 32'h1, 32'(q));
        fcyc(6'h02, 21'h00_0555, 16'h0090, q);
        fcyc(6'h00, 21'h00_0001, 16'h0000, q);
        chk("cmd part", 32'(PART), 32'(q));
        fcyc(6'h02, 21'h00_0055, 16'h0098, q);
        fcyc(6'h00, 21'h00_0010, 16'h0000, q);
        chk("query from id", 32'h51, 32'(q));
        fcyc(6'h02, 21'h00_0000, 16'h00f0, q);
        fcyc(6'h00, 21'h00_0000, 16'h0000, q);
        chk("back to id", {24'h00_0000, MAKER}, 32'(q));
        fcyc(6'h02, 21'h00_0000, 16'h00f0, q);
        fcyc(6'h06, 21'h00_00aa, 16'h0098, q);
        fcyc(6'h04, 21'h00_0020, 16'h0000, q);
        chk("byte query", 32'h51, {24'h00_0000, q[7:0]});
        fcyc(6'h06, 21'h00_0000, 16'h00f0, q);
        summarize();
    end
endmodule // flash_host_tb_top
